/* eirs_params.svh */
`ifndef EIRS_PARAMS_SVH
`define EIRS_PARAMS_SVH
// apb byte addresses
`define EIRS_ADDR_PIN_CTRL     12'h000
`define EIRS_ADDR_RST_CAUSE    12'h004
`define EIRS_ADDR_CAUSE_CTRL   12'h008
// pin control fields
`define EIRS_PIN_PULL_DIS      6
`define EIRS_PIN_EDGE_POL      5
`define EIRS_PIN_FUNC_EN       4
`define EIRS_PIN_EVT_FLAG      3
`define EIRS_PIN_EVT_ACK       2
`define EIRS_PIN_INT_EN        1
`define EIRS_PIN_DET_MODE      0
// reset cause fields, then the spare pin control bit
`define EIRS_CAUSE_POR         7
`define EIRS_CAUSE_PIN         6
`define EIRS_CAUSE_WDOG        5
`define EIRS_CAUSE_OPC         4
`define EIRS_CAUSE_ADR         3
`define EIRS_CAUSE_CLK         2
`define EIRS_CAUSE_LVD         1
`define EIRS_CAUSE_ZERO        0
`define EIRS_PIN_SPARE         7
// cause control fields
`define EIRS_CC_WDOG_EN        0
`define EIRS_CC_STOP_EN        1
`define EIRS_CC_BGND_EN        2
`define EIRS_CC_LVR_EN         3
// values
`define EIRS_SVC_FIRST         8'h55
`define EIRS_SVC_SECOND        8'haa
`define EIRS_CAUSE_RST_VAL     8'h82
`define EIRS_PIN_RST_VAL       7'h00
`define EIRS_RD_IDLE           32'h00000000
`define EIRS_CC_RST_VAL        4'h0
`endif

/* eirs_pkg.sv */
package eirs_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } eirs_apb_req_s;

  typedef struct packed {
    logic por;
    logic pin;
    logic wdog_timeout;
    logic bad_opcode;
    logic stop_exec;
    logic bgnd_exec;
    logic bad_address;
    logic clock_loss;
    logic low_voltage;
    logic debug_force;
  } eirs_reset_src_s;

  typedef enum logic [1:0] {
    EIRS_SVC_IDLE  = 2'b00,
    EIRS_SVC_ARMED = 2'b01
  } eirs_svc_e;
endpackage

/* eirs_pin_detect.sv */
`timescale 1ns/1ns
`default_nettype none
`include "eirs_params.svh"
module eirs_pin_detect
  import eirs_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_pin,
  input  wire logic i_enable,
  input  wire logic i_polarity,
  input  wire logic i_level_mode,
  output logic      o_event,
  output logic      o_asserted
);
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  wire  act_now  = sync2_ff ~^ i_polarity;
  wire  act_prev = prev_ff ~^ i_polarity;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
    end else begin
      sync1_ff <= i_pin;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  assign o_asserted = i_enable & i_level_mode & act_now;
  assign o_event    = i_enable & ((act_now & ~act_prev) | o_asserted);
endmodule
`default_nettype wire

/* eirs_top.sv */
// Summary of operation
// - pin control bit 6 set disables the internal pull device while enabled
// - bit 5 selects polarity: 0 falling/low, 1 rising/high
// - enabled pin gets pull-down for rising, pull-up for falling, unless disabled
// - bit 4 enables pin event detection; otherwise pin activity ignored
// - bit 3 is read-only event flag set by detected pin events
// - bit 2 write 1 clears flag; write 0 nothing; reads zero
// - in level mode acknowledge cannot clear flag while pin still asserted
// - bit 1 set makes an interrupt request whenever the flag is set
// - bit 0 selects edge only or edge plus level detection
// - reset cause bits 7..1: por, pin, watchdog, opcode, address, clock, voltage
// - debug forced reset leaves every cause flag cleared
// - enabled watchdog: write other than 0x55/0xaa forces watchdog reset
// - 0x55 then 0xaa restarts watchdog count, flags unchanged
// - power-on reset sets power-on and low-voltage flags, clears others
// - low-voltage reset sets voltage flag, keeps power-on, clears others
// - other resets set flags of active sources, clear inactive ones
// - watchdog source suppressed when watchdog disabled
// - opcode reset for bad opcodes, disabled stop, disabled background
// - bad address reset on unimplemented data or fetch address
// - pin reset and clock-loss reset each recorded
// - clock flag means last reset came from clock-loss detector
`timescale 1ns/1ns
`default_nettype none
`include "eirs_params.svh"
module eirs_top
  import eirs_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_rst_b,
  input  wire logic [11:0]     i_paddr,
  input  wire logic            i_psel,
  input  wire logic            i_penable,
  input  wire logic            i_pwrite,
  input  wire logic [31:0]     i_pwdata,
  output logic      [31:0]     o_prdata,
  output logic                 o_pready,
  output logic                 o_pslverr,
  input  wire logic            i_irq_pin,
  input  wire eirs_reset_src_s i_rst_src,
  output logic                 o_pull_up_en,
  output logic                 o_pull_down_en,
  output logic                 o_irq,
  output logic                 o_wdog_restart,
  output logic                 o_wdog_reset_req,
  output logic                 o_chip_reset_req,
  output logic                 o_wdog_enable,
  output logic                 o_stop_enable,
  output logic                 o_bgnd_enable,
  output logic                 o_lv_reset_enable
);
  eirs_apb_req_s req;
  logic [6:0]    pin_ctrl_ff;
  logic          flag_ff;
  logic [7:0]    cause_ff;
  logic [3:0]    cc_ff;
  logic          in_reset_ff;
  eirs_svc_e     svc_ff;
  logic [31:0]   prdata_ff;
  logic          pready_ff;
  logic          pslverr_ff;
  logic          irq_ff;
  logic          pu_ff;
  logic          pd_ff;
  logic          restart_ff;
  logic          wreset_ff;
  logic          creset_ff;
  logic          pin_evt;
  logic          pin_asserted;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    hit = (a == target);
  endfunction

  assign req = '{paddr: i_paddr, psel: i_psel, penable: i_penable, pwrite: i_pwrite, pwdata: i_pwdata};

  wire       access    = req.psel & req.penable & ~pready_ff;
  wire       sel_pin   = hit(req.paddr, `EIRS_ADDR_PIN_CTRL);
  wire       sel_cause = hit(req.paddr, `EIRS_ADDR_RST_CAUSE);
  wire       sel_cc    = hit(req.paddr, `EIRS_ADDR_CAUSE_CTRL);
  wire       mapped    = sel_pin | sel_cause | sel_cc;
  wire       wr        = access & req.pwrite;
  wire       wr_pin    = wr & sel_pin;
  wire       wr_cause  = wr & sel_cause;
  wire       wr_cc     = wr & sel_cc;
  wire [7:0] wbyte     = req.pwdata[7:0];

  wire pull_dis  = pin_ctrl_ff[`EIRS_PIN_PULL_DIS];
  wire polarity  = pin_ctrl_ff[`EIRS_PIN_EDGE_POL];
  wire func_en   = pin_ctrl_ff[`EIRS_PIN_FUNC_EN];
  wire int_en    = pin_ctrl_ff[`EIRS_PIN_INT_EN];
  wire lvl_mode  = pin_ctrl_ff[`EIRS_PIN_DET_MODE];
  wire wdog_en   = cc_ff[`EIRS_CC_WDOG_EN];

  eirs_pin_detect u_detect (
    .i_clk        (i_clk),
    .i_rst_b      (i_rst_b),
    .i_pin        (i_irq_pin),
    .i_enable     (func_en),
    .i_polarity   (polarity),
    .i_level_mode (lvl_mode),
    .o_event      (pin_evt),
    .o_asserted   (pin_asserted)
  );

  // acknowledge write clears flag unless level still asserted; event wins
  wire ack     = wr_pin & wbyte[`EIRS_PIN_EVT_ACK];
  wire nxt_flag = pin_evt | (flag_ff & ~(ack & ~pin_asserted));

  // watchdog service sequencing
  wire is_first   = (wbyte == `EIRS_SVC_FIRST);
  wire is_second  = (wbyte == `EIRS_SVC_SECOND);
  wire svc_done   = wr_cause & is_second & (svc_ff == EIRS_SVC_ARMED);
  wire bad_write  = wr_cause & wdog_en & ~is_first & ~is_second;
  eirs_svc_e nxt_svc;
  always_comb begin
    nxt_svc = svc_ff;
    unique case (svc_ff)
      EIRS_SVC_IDLE: begin
        if (wr_cause && is_first) begin
          nxt_svc = EIRS_SVC_ARMED;
        end
      end
      EIRS_SVC_ARMED: begin
        if (wr_cause && !is_first) begin
          nxt_svc = EIRS_SVC_IDLE;
        end
      end
      default: begin
        nxt_svc = EIRS_SVC_IDLE;
      end
    endcase
  end

  // reset source qualification
  wire opc_src  = i_rst_src.bad_opcode
                | (i_rst_src.stop_exec & ~cc_ff[`EIRS_CC_STOP_EN])
                | (i_rst_src.bgnd_exec & ~cc_ff[`EIRS_CC_BGND_EN]);
  wire wdog_src = wdog_en & (i_rst_src.wdog_timeout | bad_write);
  wire lv_src   = cc_ff[`EIRS_CC_LVR_EN] & i_rst_src.low_voltage;
  wire any_src  = i_rst_src.por | i_rst_src.pin | wdog_src | opc_src
                | i_rst_src.bad_address | i_rst_src.clock_loss | lv_src | i_rst_src.debug_force;

  logic [7:0] cause_capture;
  always_comb begin
    cause_capture = 8'h00;
    if (i_rst_src.por) begin
      cause_capture = `EIRS_CAUSE_RST_VAL;
    end else if (i_rst_src.debug_force) begin
      cause_capture = 8'h00;
    end else if (lv_src) begin
      cause_capture[`EIRS_CAUSE_POR] = cause_ff[`EIRS_CAUSE_POR];
      cause_capture[`EIRS_CAUSE_LVD] = 1'b1;
    end else begin
      cause_capture[`EIRS_CAUSE_PIN]  = i_rst_src.pin;
      cause_capture[`EIRS_CAUSE_WDOG] = wdog_src;
      cause_capture[`EIRS_CAUSE_OPC]  = opc_src;
      cause_capture[`EIRS_CAUSE_ADR]  = i_rst_src.bad_address;
      cause_capture[`EIRS_CAUSE_CLK]  = i_rst_src.clock_loss;
    end
  end
  // capture only on reset entry
  wire [7:0] nxt_cause = (any_src & ~in_reset_ff) ? cause_capture : cause_ff;

  // read-back assembly, pin fields one to a line, cause bits 7..1 in a loop
  wire [7:0]  pin_rd;
  wire [7:0]  cause_rd;
  assign pin_rd[`EIRS_PIN_SPARE]    = 1'b0;
  assign pin_rd[`EIRS_PIN_PULL_DIS] = pull_dis;
  assign pin_rd[`EIRS_PIN_EDGE_POL] = polarity;
  assign pin_rd[`EIRS_PIN_FUNC_EN]  = func_en;
  assign pin_rd[`EIRS_PIN_EVT_FLAG] = flag_ff;
  assign pin_rd[`EIRS_PIN_EVT_ACK]  = 1'b0;
  assign pin_rd[`EIRS_PIN_INT_EN]   = int_en;
  assign pin_rd[`EIRS_PIN_DET_MODE] = lvl_mode;
  assign cause_rd[`EIRS_CAUSE_ZERO] = 1'b0;
  for (genvar g = `EIRS_CAUSE_LVD; g <= `EIRS_CAUSE_POR; g++) begin : g_cause_rd
    assign cause_rd[g] = cause_ff[g];
  end
  wire [31:0] rd_word = sel_pin   ? {24'h000000, pin_rd} :
                        sel_cause ? {24'h000000, cause_rd} :
                        sel_cc    ? {28'h0000000, cc_ff} : `EIRS_RD_IDLE;

  // write path stores only the control fields
  wire [6:0]  wr_ctrl;
  assign wr_ctrl[`EIRS_PIN_PULL_DIS] = wbyte[`EIRS_PIN_PULL_DIS];
  assign wr_ctrl[`EIRS_PIN_EDGE_POL] = wbyte[`EIRS_PIN_EDGE_POL];
  assign wr_ctrl[`EIRS_PIN_FUNC_EN]  = wbyte[`EIRS_PIN_FUNC_EN];
  assign wr_ctrl[`EIRS_PIN_EVT_FLAG] = 1'b0;
  assign wr_ctrl[`EIRS_PIN_EVT_ACK]  = 1'b0;
  assign wr_ctrl[`EIRS_PIN_INT_EN]   = wbyte[`EIRS_PIN_INT_EN];
  assign wr_ctrl[`EIRS_PIN_DET_MODE] = wbyte[`EIRS_PIN_DET_MODE];
  wire [6:0]  nxt_pin_ctrl = wr_pin ? wr_ctrl : pin_ctrl_ff;

  wire [3:0]  nxt_cc       = wr_cc ? wbyte[3:0] : cc_ff;
  // pull device control follows enable, polarity and disable
  wire        nxt_pu       = func_en & ~pull_dis & ~polarity;
  wire        nxt_pd       = func_en & ~pull_dis & polarity;
  wire        nxt_irq      = int_en & nxt_flag;

  // bus answer and watchdog pulses, registered once
  wire [31:0] nxt_prdata   = access ? rd_word : `EIRS_RD_IDLE;
  wire        nxt_pready   = access;
  wire        nxt_pslverr  = access & ~mapped;
  wire        nxt_restart  = svc_done;
  wire        nxt_wreset   = bad_write;
  wire        nxt_creset   = any_src & ~in_reset_ff;

  // pin control and interrupt registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pin_ctrl_ff <= `EIRS_PIN_RST_VAL;
    end else begin
      pin_ctrl_ff <= nxt_pin_ctrl;
    end
  end

  // event wins over an acknowledge in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cc_ff <= `EIRS_CC_RST_VAL;
    end else begin
      cc_ff <= nxt_cc;
    end
  end

  // service sequencer state
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      svc_ff <= EIRS_SVC_IDLE;
    end else begin
      svc_ff <= nxt_svc;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pu_ff <= 1'b0;
    end else begin
      pu_ff <= nxt_pu;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pd_ff <= 1'b0;
    end else begin
      pd_ff <= nxt_pd;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // cause register survives system reset; only power-on preloads it
  always_ff @(posedge i_clk) begin
    cause_ff <= nxt_cause;
  end

  always_ff @(posedge i_clk) begin
    in_reset_ff <= any_src;
  end

  // bus answer and watchdog pulse registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prdata_ff <= `EIRS_RD_IDLE;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // one wait state: answer follows the access edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= nxt_pready;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= nxt_pslverr;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= nxt_restart;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wreset_ff <= 1'b0;
    end else begin
      wreset_ff <= nxt_wreset;
    end
  end

  // pulse on the first cycle of any qualified reset source
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      creset_ff <= 1'b0;
    end else begin
      creset_ff <= nxt_creset;
    end
  end

  assign o_prdata          = prdata_ff;
  assign o_pready          = pready_ff;
  assign o_pslverr         = pslverr_ff;
  assign o_irq             = irq_ff;
  assign o_pull_up_en      = pu_ff;
  assign o_pull_down_en    = pd_ff;
  assign o_wdog_restart    = restart_ff;
  assign o_wdog_reset_req  = wreset_ff;
  assign o_chip_reset_req  = creset_ff;
  assign o_wdog_enable     = cc_ff[`EIRS_CC_WDOG_EN];
  assign o_stop_enable     = cc_ff[`EIRS_CC_STOP_EN];
  assign o_bgnd_enable     = cc_ff[`EIRS_CC_BGND_EN];
  assign o_lv_reset_enable = cc_ff[`EIRS_CC_LVR_EN];
endmodule
`default_nettype wire

/* eirs_top_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module eirs_top_chk
  import eirs_pkg::*;
(
  input wire logic            i_clk,
  input wire logic            i_rst_b,
  input wire logic [11:0]     i_paddr,
  input wire logic            i_psel,
  input wire logic            i_penable,
  input wire logic            i_pwrite,
  input wire logic [31:0]     i_pwdata,
  input wire logic [31:0]     o_prdata,
  input wire logic            o_pready,
  input wire logic            o_pslverr,
  input wire eirs_reset_src_s i_rst_src,
  input wire logic            o_wdog_restart,
  input wire logic            o_wdog_reset_req,
  input wire logic            o_chip_reset_req,
  input wire logic            o_wdog_enable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire acc = i_psel && i_penable && !o_pready;
  wire cw  = i_pwrite && i_paddr == 12'h004;
  wire bad = i_pwdata[7:0] != 8'h55 && i_pwdata[7:0] != 8'haa;
  wire rd  = o_pready && !i_pwrite;
  sequence s_acc; acc; endsequence
  property p_answer; s_acc |=> o_pready; endproperty
  property p_restart; o_wdog_restart |-> o_pready && cw && i_pwdata[7:0] == 8'haa; endproperty
  property p_req; s_acc ##0 (cw && bad && o_wdog_enable) |=> o_wdog_reset_req; endproperty
  property p_req_src; o_wdog_reset_req |-> o_wdog_enable && o_pready && cw && bad; endproperty
  property p_ack_rd; rd && i_paddr == 12'h000 |-> o_prdata[2] == 1'b0 && o_prdata[31:8] == 24'h000000; endproperty
  property p_cause_rd; rd && i_paddr == 12'h004 |-> o_prdata[0] == 1'b0; endproperty
  property p_unmapped; o_pready && i_paddr > 12'h008 |-> o_pslverr && o_prdata == 32'h00000000; endproperty
  property p_entry; $rose(i_rst_src.por) |=> o_chip_reset_req; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  a_restart: assert property (p_restart) else $error("stray restart");
  a_req: assert property (p_req) else $error("missing reset req");
  a_req_src: assert property (p_req_src) else $error("stray reset req");
  a_ack_rd: assert property (p_ack_rd) else $error("ack reads one");
  a_cause_rd: assert property (p_cause_rd) else $error("cause bit0 set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped answer");
  a_entry: assert property (p_entry) else $error("no entry pulse");
endmodule
`default_nettype wire

/* eirs_irq_drv.sv */
`timescale 1ns/1ns
`default_nettype none
module eirs_irq_drv (
  input  wire logic i_clk,
  input  wire logic i_drive,
  input  wire logic i_level,
  input  wire logic i_pull_up_en,
  input  wire logic i_pull_down_en,
  output logic      o_pin
);
  logic last_ff;
  always_ff @(posedge i_clk) if (i_drive) last_ff <= i_level;
  // released line goes to the pull level, else drifts off its last value
  assign o_pin = i_drive ? i_level : i_pull_up_en ? 1'b1 : i_pull_down_en ? 1'b0 : ~last_ff;
endmodule
`default_nettype wire

/* test_ext_pin_irq_and_reset_status.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("unexpected %s exp %h got %h", n, e, g); \
  end \
end
module test_ext_pin_irq_and_reset_status;
  import eirs_pkg::*;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, drv = 1, lvl = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, pin, pu, pd, irq, crq, wd, st, bg, lv, wrs, wrq;
  eirs_reset_src_s src = 10'h000;
  int err_total = 0, checked = 0, cyc = 0, n_rs = 0, n_rq = 0;
  logic [9:0] srcs [13] = '{10'h200, 10'h002, 10'h108, 10'h002, 10'h101, 10'h004, 10'h010,
                            10'h008, 10'h020, 10'h080, 10'h080, 10'h020, 10'h010};
  logic [7:0] exps [13] = '{8'h82, 8'h82, 8'h48, 8'h02, 8'h00, 8'h04, 8'h10,
                            8'h08, 8'h10, 8'h10, 8'h20, 8'h20, 8'h20};
  eirs_top dut (.i_clk(clk), .i_rst_b(rst_b), .i_paddr(paddr), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_irq_pin(pin),
    .i_rst_src(src), .o_pull_up_en(pu), .o_pull_down_en(pd), .o_irq(irq), .o_wdog_restart(wrs),
    .o_wdog_reset_req(wrq), .o_chip_reset_req(crq), .o_wdog_enable(wd), .o_stop_enable(st),
    .o_bgnd_enable(bg), .o_lv_reset_enable(lv));
  eirs_irq_drv drv_i (.i_clk(clk), .i_drive(drv), .i_level(lvl), .i_pull_up_en(pu), .i_pull_down_en(pd), .o_pin(pin));
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (wrs === 1'b1) n_rs++;
    if (wrq === 1'b1) n_rq++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic end_sim;
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK("read data", {24'h000000, e}, rdat)
  endtask
  initial begin
    tick(3);
    rst_b <= 1'b1;
    tick(1);
    rd(12'h000, 8'h00);
    rd(12'h008, 8'h00);
    xfer(1'b0, 12'h00c, 8'h00);
    `CHK("slave error", 1'b1, rerr)
    wr(12'h008, 8'h08);
    rd(12'h008, 8'h08);
    for (int i = 0; i < 13; i++) begin
      if (i == 10) wr(12'h008, 8'h07);
      src <= srcs[i];
      tick(1);
      src <= 10'h000;
      tick(3);
      rd(12'h004, exps[i]);
    end
    `CHK("enables", 4'h7, {lv, bg, st, wd})
    wr(12'h004, 8'h55);
    wr(12'h004, 8'haa);
    rd(12'h004, 8'h20);
    wr(12'h004, 8'haa);
    `CHK("restarts", 1, n_rs)
    wr(12'h004, 8'h12);
    tick(2);
    `CHK("reset reqs", 1, n_rq)
    wr(12'h000, 8'h10);
    tick(2);
    `CHK("pulls", 2'b10, {pu, pd})
    lvl <= 1'b0;
    tick(6);
    rd(12'h000, 8'h18);
    `CHK("irq", 1'b0, irq)
    wr(12'h000, 8'h12);
    `CHK("irq", 1'b1, irq)
    wr(12'h000, 8'h16);
    rd(12'h000, 8'h12);
    wr(12'h000, 8'h1a);
    rd(12'h000, 8'h12);
    wr(12'h000, 8'h13);
    tick(4);
    rd(12'h000, 8'h1b);
    wr(12'h000, 8'h17);
    rd(12'h000, 8'h1b);
    lvl <= 1'b1;
    tick(6);
    wr(12'h000, 8'h17);
    rd(12'h000, 8'h13);
    wr(12'h000, 8'h70);
    tick(2);
    `CHK("pulls", 2'b00, {pu, pd})
    wr(12'h000, 8'h34);
    tick(2);
    `CHK("pulls", 2'b01, {pu, pd})
    wr(12'h000, 8'h34);
    lvl <= 1'b0;
    tick(6);
    rd(12'h000, 8'h30);
    lvl <= 1'b1;
    tick(6);
    rd(12'h000, 8'h38);
    wr(12'h000, 8'h04);
    lvl <= 1'b0;
    tick(6);
    lvl <= 1'b1;
    tick(6);
    rd(12'h000, 8'h00);
    wr(12'h000, 8'h14);
    drv <= 1'b0;
    lvl <= 1'b0;
    tick(6);
    rd(12'h000, 8'h10);
    end_sim();
  end
endmodule
bind eirs_top eirs_top_chk chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_paddr(i_paddr), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_rst_src(i_rst_src), .o_wdog_restart(o_wdog_restart),
  .o_wdog_reset_req(o_wdog_reset_req), .o_chip_reset_req(o_chip_reset_req), .o_wdog_enable(o_wdog_enable));
`default_nettype wire
